// >>> verilog/tail_exec_pkg.sv
// Shared constants and carrier types for the tail instruction execute block.
package tail_exec_pkg;

	// ********************************
	// Widths and program memory layout
	// ********************************
	localparam int data_width = 8;
	localparam int low_width = 8;
	localparam int page_width = 4;
	localparam int prog_addr_width = page_width + low_width;
	localparam int prog_word_width = 16;
	localparam int reg_addr_width = 3;
	localparam logic [page_width-1:0] last_page = 4'hf;

	// ********************************
	// Register offsets
	// ********************************
	localparam logic [reg_addr_width-1:0] off_accumulator = 3'h0;
	localparam logic [reg_addr_width-1:0] off_status = 3'h1;
	localparam logic [reg_addr_width-1:0] off_table_low_pointer = 3'h2;
	localparam logic [reg_addr_width-1:0] off_table_page_pointer = 3'h3;
	localparam logic [reg_addr_width-1:0] off_table_high_register = 3'h4;

	// ********************************
	// Status field positions and reset values
	// ********************************
	localparam int pos_null = 0;
	localparam int pos_carry = 1;
	localparam int pos_aux = 2;
	localparam int pos_overflow = 3;
	localparam int flag_width = 4;
	localparam logic [data_width-1:0] reset_byte = 8'h00;
	localparam logic [flag_width-1:0] reset_flags = 4'h0;
	localparam logic [page_width-1:0] reset_page = 4'h0;

	// ********************************
	// Operation codes
	// ********************************
	typedef enum logic [3:0] {
		op_none = 4'h0,
		op_nibble_exchange_to_accumulator = 4'h1,
		op_skip_on_null_byte = 4'h2,
		op_copy_and_skip_on_null = 4'h3,
		op_skip_on_null_bit = 4'h4,
		op_table_read_specific_page = 4'h5,
		op_table_read_current_page = 4'h6,
		op_table_read_last_page = 4'h7,
		op_exclusive_or_to_accumulator = 4'h8,
		op_exclusive_or_to_memory = 4'h9,
		op_exclusive_or_immediate = 4'ha
	} op_type;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_table_wait = 3'b010,
		st_dummy = 3'b100
	} fsm_type;

	typedef struct packed {
		logic valid;
		op_type code;
		logic [2:0] bit_sel;
		logic [data_width-1:0] immediate;
		logic [data_width-1:0] mem_byte;
	} instr_type;

	typedef struct packed {
		logic we;
		logic [data_width-1:0] wdata;
	} mem_write_type;

	typedef struct packed {
		logic rd;
		logic [prog_addr_width-1:0] addr;
	} prog_req_type;

	typedef struct packed {
		fsm_type fsm;
		logic [data_width-1:0] accumulator_register;
		logic [flag_width-1:0] flags;
		logic [low_width-1:0] table_low_pointer;
		logic [page_width-1:0] table_page_pointer;
		logic [data_width-1:0] table_high_register;
		mem_write_type mem_write;
		prog_req_type prog_req;
		logic skip_taken;
		logic ready;
		logic [data_width-1:0] rdata;
	} state_type;

endpackage

// >>> verilog/tail_exec.sv
// Execute stage for swap, zero-skip, table read and exclusive-OR instructions.
// Contract
// - Swap nibbles into accumulator, memory and flags kept.
// - Null byte skips the following instruction.
// - Copy byte to accumulator, skip when null.
// - Selected bit zero skips the following instruction.
// - Taken skip adds one dummy cycle.
// - Specific page word: low to memory, high to register.
// - Current page word: low to memory, high to register.
// - Last page word: low to memory, high to register.
// - Accumulator xor memory into accumulator.
// - Accumulator xor memory back into memory.
// - Accumulator xor immediate into accumulator.
`timescale 1ns/1ps
module tail_exec (
	input wire logic mclk,
	input wire logic rst,
	input wire tail_exec_pkg::instr_type instr,
	input wire logic [tail_exec_pkg::page_width-1:0] current_page,
	input wire logic [tail_exec_pkg::prog_word_width-1:0] prog_rdata,
	input wire logic [tail_exec_pkg::reg_addr_width-1:0] reg_addr,
	input wire logic [tail_exec_pkg::data_width-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output tail_exec_pkg::mem_write_type mem_write,
	output tail_exec_pkg::prog_req_type prog_req,
	output logic skip_taken,
	output logic ready,
	output logic [tail_exec_pkg::data_width-1:0] reg_rdata
);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic is_null(input logic [tail_exec_pkg::data_width-1:0] value);
		is_null = (value == tail_exec_pkg::reset_byte);
	endfunction

	function automatic logic [tail_exec_pkg::data_width-1:0] nibble_swap(
		input logic [tail_exec_pkg::data_width-1:0] value);
		nibble_swap = {value[3:0], value[7:4]};
	endfunction

	// Opcode groups shared by the checks below.
	function automatic logic is_xor_op(input tail_exec_pkg::op_type code);
		is_xor_op = (code == tail_exec_pkg::op_exclusive_or_to_accumulator)
			|| (code == tail_exec_pkg::op_exclusive_or_to_memory)
			|| (code == tail_exec_pkg::op_exclusive_or_immediate);
	endfunction

	function automatic logic is_skip_op(input tail_exec_pkg::op_type code);
		is_skip_op = (code == tail_exec_pkg::op_skip_on_null_byte)
			|| (code == tail_exec_pkg::op_copy_and_skip_on_null)
			|| (code == tail_exec_pkg::op_skip_on_null_bit);
	endfunction

	function automatic logic writes_acc(input tail_exec_pkg::op_type code);
		writes_acc = (code == tail_exec_pkg::op_nibble_exchange_to_accumulator)
			|| (code == tail_exec_pkg::op_copy_and_skip_on_null)
			|| (code == tail_exec_pkg::op_exclusive_or_to_accumulator)
			|| (code == tail_exec_pkg::op_exclusive_or_immediate);
	endfunction

	tail_exec_pkg::state_type cur;
	tail_exec_pkg::state_type next_cur;
	logic accept;
	logic [tail_exec_pkg::data_width-1:0] xor_mem;
	logic [tail_exec_pkg::data_width-1:0] xor_imm;

	// An instruction is taken only while idle; the fetch stage waits on ready.
	assign accept = instr.valid && (cur.fsm == tail_exec_pkg::st_idle);
	assign xor_mem = cur.accumulator_register ^ instr.mem_byte;
	assign xor_imm = cur.accumulator_register ^ instr.immediate;

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		next_cur = cur;
		next_cur.mem_write.we = 1'b0;
		next_cur.prog_req.rd = 1'b0;
		next_cur.skip_taken = 1'b0;
		next_cur.rdata = tail_exec_pkg::reset_byte;
		// Software writes first, so a same-cycle instruction result overrides them.
		if (reg_write) begin
			unique case (reg_addr)
				tail_exec_pkg::off_accumulator: next_cur.accumulator_register = reg_wdata;
				tail_exec_pkg::off_status: next_cur.flags = reg_wdata[tail_exec_pkg::flag_width-1:0];
				tail_exec_pkg::off_table_low_pointer: next_cur.table_low_pointer = reg_wdata;
				tail_exec_pkg::off_table_page_pointer:
					next_cur.table_page_pointer = reg_wdata[tail_exec_pkg::page_width-1:0];
				tail_exec_pkg::off_table_high_register: next_cur.table_high_register = reg_wdata;
				default: next_cur.flags = next_cur.flags;
			endcase
		end
		if (reg_read) begin
			unique case (reg_addr)
				tail_exec_pkg::off_accumulator: next_cur.rdata = cur.accumulator_register;
				tail_exec_pkg::off_status: next_cur.rdata = {4'h0, cur.flags};
				tail_exec_pkg::off_table_low_pointer: next_cur.rdata = cur.table_low_pointer;
				tail_exec_pkg::off_table_page_pointer: next_cur.rdata = {4'h0, cur.table_page_pointer};
				tail_exec_pkg::off_table_high_register: next_cur.rdata = cur.table_high_register;
				default: next_cur.rdata = tail_exec_pkg::reset_byte;
			endcase
		end
		unique case (cur.fsm)
			tail_exec_pkg::st_idle: begin
				if (accept) begin
					unique case (instr.code)
						tail_exec_pkg::op_nibble_exchange_to_accumulator: begin
							next_cur.accumulator_register = nibble_swap(instr.mem_byte);
						end
						tail_exec_pkg::op_skip_on_null_byte: begin
							next_cur.skip_taken = is_null(instr.mem_byte);
						end
						tail_exec_pkg::op_copy_and_skip_on_null: begin
							next_cur.accumulator_register = instr.mem_byte;
							next_cur.skip_taken = is_null(instr.mem_byte);
						end
						tail_exec_pkg::op_skip_on_null_bit: begin
							next_cur.skip_taken = ~instr.mem_byte[instr.bit_sel];
						end
						tail_exec_pkg::op_table_read_specific_page: begin
							next_cur.prog_req.rd = 1'b1;
							next_cur.prog_req.addr = {cur.table_page_pointer, cur.table_low_pointer};
						end
						tail_exec_pkg::op_table_read_current_page: begin
							next_cur.prog_req.rd = 1'b1;
							next_cur.prog_req.addr = {current_page, cur.table_low_pointer};
						end
						tail_exec_pkg::op_table_read_last_page: begin
							next_cur.prog_req.rd = 1'b1;
							next_cur.prog_req.addr = {tail_exec_pkg::last_page, cur.table_low_pointer};
						end
						tail_exec_pkg::op_exclusive_or_to_accumulator: begin
							next_cur.accumulator_register = xor_mem;
							next_cur.flags[tail_exec_pkg::pos_null] = is_null(xor_mem);
						end
						tail_exec_pkg::op_exclusive_or_to_memory: begin
							next_cur.mem_write.we = 1'b1;
							next_cur.mem_write.wdata = xor_mem;
							next_cur.flags[tail_exec_pkg::pos_null] = is_null(xor_mem);
						end
						tail_exec_pkg::op_exclusive_or_immediate: begin
							next_cur.accumulator_register = xor_imm;
							next_cur.flags[tail_exec_pkg::pos_null] = is_null(xor_imm);
						end
						default: next_cur.skip_taken = 1'b0;
					endcase
					if (next_cur.skip_taken) begin
						next_cur.fsm = tail_exec_pkg::st_dummy;
					end else if (next_cur.prog_req.rd) begin
						next_cur.fsm = tail_exec_pkg::st_table_wait;
					end
				end
			end
			tail_exec_pkg::st_table_wait: begin
				// Program memory answers in the cycle after the request, so the word is taken one edge later.
				if (!cur.prog_req.rd) begin
					next_cur.table_high_register = prog_rdata[15:8];
					next_cur.mem_write.we = 1'b1;
					next_cur.mem_write.wdata = prog_rdata[7:0];
					next_cur.fsm = tail_exec_pkg::st_idle;
				end
			end
			tail_exec_pkg::st_dummy: begin
				// The skipped instruction is fetched and discarded here.
				next_cur.fsm = tail_exec_pkg::st_idle;
			end
			default: next_cur.fsm = tail_exec_pkg::st_idle;
		endcase
		next_cur.ready = (next_cur.fsm == tail_exec_pkg::st_idle);
		if (rst) begin
			next_cur.fsm = tail_exec_pkg::st_idle;
			next_cur.accumulator_register = tail_exec_pkg::reset_byte;
			next_cur.flags = tail_exec_pkg::reset_flags;
			next_cur.table_low_pointer = tail_exec_pkg::reset_byte;
			next_cur.table_page_pointer = tail_exec_pkg::reset_page;
			next_cur.table_high_register = tail_exec_pkg::reset_byte;
			next_cur.mem_write = '0;
			next_cur.prog_req = '0;
			next_cur.skip_taken = 1'b0;
			next_cur.ready = 1'b0;
			next_cur.rdata = tail_exec_pkg::reset_byte;
		end
	end

	always_ff @(posedge mclk) begin
		cur <= next_cur;
	end

	assign mem_write = cur.mem_write;
	assign prog_req = cur.prog_req;
	assign skip_taken = cur.skip_taken;
	assign ready = cur.ready;
	assign reg_rdata = cur.rdata;

	// ********************************
	// Assertions
	// ********************************
	logic quiet_bus;
	assign quiet_bus = !reg_write;

	a_swap_nibbles: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_nibble_exchange_to_accumulator
		|=> cur.accumulator_register == {$past(instr.mem_byte[3:0]), $past(instr.mem_byte[7:4])}
			&& !mem_write.we && $stable(cur.flags))
		else $error("nibble exchange result wrong");

	a_skip_null_byte: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_skip_on_null_byte
		|=> skip_taken == ($past(instr.mem_byte) == 8'h00) && $stable(cur.flags))
		else $error("null byte skip decision wrong");

	a_copy_skip: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_copy_and_skip_on_null
		|=> cur.accumulator_register == $past(instr.mem_byte)
			&& skip_taken == ($past(instr.mem_byte) == 8'h00))
		else $error("copy and skip wrong");

	a_skip_null_bit: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_skip_on_null_bit
		|=> skip_taken == !$past(instr.mem_byte[instr.bit_sel]))
		else $error("bit skip decision wrong");

	a_dummy_cycle: assert property (@(posedge mclk) disable iff (rst)
		skip_taken |-> !ready ##1 (ready && !skip_taken))
		else $error("taken skip not two cycles");

	a_table_specific: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_table_read_specific_page
		|=> prog_req.rd && prog_req.addr == {$past(cur.table_page_pointer), $past(cur.table_low_pointer)})
		else $error("specific page address wrong");

	a_table_current: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_table_read_current_page
		|=> prog_req.rd && prog_req.addr == {$past(current_page), $past(cur.table_low_pointer)})
		else $error("current page address wrong");

	a_table_last: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_table_read_last_page
		|=> prog_req.rd && prog_req.addr == {tail_exec_pkg::last_page, $past(cur.table_low_pointer)})
		else $error("last page address wrong");

	a_table_data: assert property (@(posedge mclk) disable iff (rst)
		prog_req.rd |=> ##1 (mem_write.we && mem_write.wdata == $past(prog_rdata[7:0])
			&& cur.table_high_register == $past(prog_rdata[15:8]) && ready))
		else $error("table word not delivered");

	a_xor_acc: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_exclusive_or_to_accumulator
		|=> cur.accumulator_register == ($past(cur.accumulator_register) ^ $past(instr.mem_byte)))
		else $error("xor to accumulator wrong");

	a_xor_mem: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_exclusive_or_to_memory && quiet_bus
		|=> mem_write.we && mem_write.wdata == ($past(cur.accumulator_register) ^ $past(instr.mem_byte))
			&& $stable(cur.accumulator_register))
		else $error("xor to memory wrong");

	a_xor_imm: assert property (@(posedge mclk) disable iff (rst)
		accept && instr.code == tail_exec_pkg::op_exclusive_or_immediate
		|=> cur.accumulator_register == ($past(cur.accumulator_register) ^ $past(instr.immediate)))
		else $error("xor immediate wrong");

	a_null_flag: assert property (@(posedge mclk) disable iff (rst)
		accept && quiet_bus && (instr.code == tail_exec_pkg::op_exclusive_or_to_accumulator
			|| instr.code == tail_exec_pkg::op_exclusive_or_immediate)
		|=> cur.flags[0] == (cur.accumulator_register == 8'h00) && cur.flags[3:1] == $past(cur.flags[3:1]))
		else $error("null flag or kept flags wrong");

	a_xor_mem_flag: assert property (@(posedge mclk) disable iff (rst)
		accept && quiet_bus && instr.code == tail_exec_pkg::op_exclusive_or_to_memory
		|=> cur.flags[tail_exec_pkg::pos_null] == (mem_write.wdata == 8'h00)
			&& cur.flags[3:1] == $past(cur.flags[3:1]))
		else $error("null flag after xor to memory wrong");

	a_copy_flags: assert property (@(posedge mclk) disable iff (rst)
		accept && quiet_bus && instr.code == tail_exec_pkg::op_copy_and_skip_on_null
		|=> $stable(cur.flags) && !mem_write.we)
		else $error("copy and skip touched flags or memory");

	a_bit_flags: assert property (@(posedge mclk) disable iff (rst)
		accept && quiet_bus && instr.code == tail_exec_pkg::op_skip_on_null_bit
		|=> $stable(cur.flags) && $stable(cur.accumulator_register))
		else $error("bit skip touched flags or accumulator");

	a_skip_acc: assert property (@(posedge mclk) disable iff (rst)
		accept && quiet_bus && instr.code == tail_exec_pkg::op_skip_on_null_byte
		|=> $stable(cur.accumulator_register) && !mem_write.we)
		else $error("null byte skip touched accumulator or memory");

	// Only a skip instruction may raise the skip, or the fetch stage would drop a live instruction.
	a_skip_src: assert property (@(posedge mclk) disable iff (rst)
		skip_taken |-> $past(accept && is_skip_op(instr.code)))
		else $error("skip raised without a skip instruction");

	a_table_busy: assert property (@(posedge mclk) disable iff (rst)
		prog_req.rd |-> !ready ##1 !ready ##1 ready)
		else $error("table read busy time wrong");

	a_rd_pulse: assert property (@(posedge mclk) disable iff (rst)
		prog_req.rd |=> !prog_req.rd)
		else $error("program read longer than one cycle");

	a_table_quiet: assert property (@(posedge mclk) disable iff (rst)
		cur.fsm == tail_exec_pkg::st_table_wait && !reg_write
		|=> $stable(cur.flags) && $stable(cur.accumulator_register))
		else $error("table read touched flags or accumulator");

	a_table_high_src: assert property (@(posedge mclk) disable iff (rst)
		$changed(cur.table_high_register)
		|-> $past(reg_write) || $past(cur.fsm == tail_exec_pkg::st_table_wait))
		else $error("table high register changed without a table read");

	// Memory is written only by the xor to memory and the end of a table read.
	a_mem_write_src: assert property (@(posedge mclk) disable iff (rst)
		mem_write.we |-> $past(accept && instr.code == tail_exec_pkg::op_exclusive_or_to_memory)
			|| $past(cur.fsm == tail_exec_pkg::st_table_wait && !cur.prog_req.rd))
		else $error("memory written by a wrong instruction");

	a_we_pulse: assert property (@(posedge mclk) disable iff (rst)
		mem_write.we |=> !mem_write.we)
		else $error("memory write longer than one cycle");

	a_xor_acc_mem: assert property (@(posedge mclk) disable iff (rst)
		accept && (instr.code == tail_exec_pkg::op_exclusive_or_to_accumulator
			|| instr.code == tail_exec_pkg::op_exclusive_or_immediate)
		|=> !mem_write.we)
		else $error("xor into accumulator wrote memory");

	a_flags_hold: assert property (@(posedge mclk) disable iff (rst)
		$changed(cur.flags) |-> $past(reg_write) || $past(accept && is_xor_op(instr.code)))
		else $error("flags changed without an xor instruction");

	a_acc_hold: assert property (@(posedge mclk) disable iff (rst)
		$changed(cur.accumulator_register)
		|-> $past(reg_write) || $past(accept && writes_acc(instr.code)))
		else $error("accumulator changed by a wrong instruction");

endmodule

// >>> verification/tb_top.sv
// Self-checking testbench for the tail instruction execute block.
`timescale 1ns/1ps
module tb_top;
	// ********************************
	// Signals
	// ********************************
	logic mclk;
	logic rst;
	tail_exec_pkg::instr_type instr;
	logic [tail_exec_pkg::page_width-1:0] current_page;
	logic [tail_exec_pkg::prog_word_width-1:0] prog_rdata;
	logic [tail_exec_pkg::reg_addr_width-1:0] reg_addr;
	logic [tail_exec_pkg::data_width-1:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	tail_exec_pkg::mem_write_type mem_write;
	tail_exec_pkg::prog_req_type prog_req;
	logic skip_taken;
	logic ready;
	logic [tail_exec_pkg::data_width-1:0] reg_rdata;
	int bad_count;
	int checks_done;

	tail_exec dut (.mclk(mclk), .rst(rst), .instr(instr), .current_page(current_page), .prog_rdata(prog_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.mem_write(mem_write), .prog_req(prog_req), .skip_taken(skip_taken), .ready(ready), .reg_rdata(reg_rdata));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask

	// The answer stands only in the cycle after the strobe, so it is looked at there.
	task automatic reg_check(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	task automatic exec(input tail_exec_pkg::op_type op, input logic [2:0] bsel, input logic [7:0] imm,
		input logic [7:0] mem);
		@(posedge mclk);
		instr <= '{1'b1, op, bsel, imm, mem};
		@(posedge mclk);
		instr.valid <= 1'b0;
		#1;
	endtask

	task automatic skip_chk(input tail_exec_pkg::op_type op, input logic [2:0] bsel, input logic [7:0] mem,
		input logic exp);
		exec(op, bsel, 8'h00, mem);
		chk(skip_taken, exp);
		chk(ready, !exp);
		@(posedge mclk);
		#1;
		chk(skip_taken, 1'b0);
		chk(ready, 1'b1);
	endtask

	// Outside its valid cycle the program word is inverted so a late sample cannot match.
	task automatic tbl(input tail_exec_pkg::op_type op, input logic [11:0] exp_addr, input logic [15:0] word);
		prog_rdata <= ~word;
		exec(op, 3'h0, 8'h00, 8'h00);
		chk(prog_req.rd, 1'b1);
		chk(prog_req.addr, exp_addr);
		chk(ready, 1'b0);
		@(posedge mclk);
		prog_rdata <= word;
		#1;
		chk(ready, 1'b0);
		chk(prog_req.rd, 1'b0);
		@(posedge mclk);
		prog_rdata <= ~word;
		#1;
		chk(mem_write.we, 1'b1);
		chk(mem_write.wdata, word[7:0]);
		chk(ready, 1'b1);
		reg_check(tail_exec_pkg::off_table_high_register, word[15:8]);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rst = 1'b1;
		instr = '0;
		current_page = 4'h7;
		prog_rdata = 16'h0000;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		bad_count = 0;
		checks_done = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i <= 20; i++) begin
			@(posedge mclk);
			#1;
			if (ready === 1'b1) break;
			if (i == 20) begin
				bad_count++;
				summarize();
			end
		end
		for (int a = 0; a < 8; a++) reg_check(a[2:0], 8'h00);
		reg_wr(tail_exec_pkg::off_status, 8'h06);
		reg_check(tail_exec_pkg::off_status, 8'h06);
		$display("Test registers done");
		exec(tail_exec_pkg::op_nibble_exchange_to_accumulator, 3'h0, 8'h00, 8'h3c);
		chk(mem_write.we, 1'b0);
		reg_check(tail_exec_pkg::off_accumulator, 8'hc3);
		reg_check(tail_exec_pkg::off_status, 8'h06);
		$display("Test swap done");
		exec(tail_exec_pkg::op_exclusive_or_to_accumulator, 3'h0, 8'h00, 8'hc3);
		reg_check(tail_exec_pkg::off_accumulator, 8'h00);
		reg_check(tail_exec_pkg::off_status, 8'h07);
		exec(tail_exec_pkg::op_exclusive_or_immediate, 3'h0, 8'h5a, 8'hff);
		reg_check(tail_exec_pkg::off_accumulator, 8'h5a);
		reg_check(tail_exec_pkg::off_status, 8'h06);
		exec(tail_exec_pkg::op_exclusive_or_to_memory, 3'h0, 8'h00, 8'h0f);
		chk(mem_write.we, 1'b1);
		chk(mem_write.wdata, 8'h55);
		reg_check(tail_exec_pkg::off_accumulator, 8'h5a);
		exec(tail_exec_pkg::op_exclusive_or_to_memory, 3'h0, 8'h00, 8'h5a);
		chk(mem_write.wdata, 8'h00);
		reg_check(tail_exec_pkg::off_status, 8'h07);
		reg_wr(tail_exec_pkg::off_status, 8'h06);
		$display("Test xor done");
		skip_chk(tail_exec_pkg::op_skip_on_null_byte, 3'h0, 8'h00, 1'b1);
		skip_chk(tail_exec_pkg::op_skip_on_null_byte, 3'h0, 8'h80, 1'b0);
		skip_chk(tail_exec_pkg::op_copy_and_skip_on_null, 3'h0, 8'h00, 1'b1);
		reg_check(tail_exec_pkg::off_accumulator, 8'h00);
		skip_chk(tail_exec_pkg::op_copy_and_skip_on_null, 3'h0, 8'h81, 1'b0);
		reg_check(tail_exec_pkg::off_accumulator, 8'h81);
		for (int b = 0; b < 8; b++) begin
			skip_chk(tail_exec_pkg::op_skip_on_null_bit, b[2:0], ~(8'h01 << b), 1'b1);
			skip_chk(tail_exec_pkg::op_skip_on_null_bit, b[2:0], 8'h01 << b, 1'b0);
		end
		reg_check(tail_exec_pkg::off_status, 8'h06);
		$display("Test skip done");
		reg_wr(tail_exec_pkg::off_table_low_pointer, 8'h9c);
		reg_wr(tail_exec_pkg::off_table_page_pointer, 8'h05);
		tbl(tail_exec_pkg::op_table_read_specific_page, 12'h59c, 16'hbe21);
		tbl(tail_exec_pkg::op_table_read_current_page, 12'h79c, 16'h4d00);
		tbl(tail_exec_pkg::op_table_read_last_page, 12'hf9c, 16'h12ef);
		reg_check(tail_exec_pkg::off_status, 8'h06);
		$display("Test table done");
		summarize();
	end

	// A hang anywhere above is cut short here and counted as a mismatch.
	initial begin
		#200us;
		bad_count++;
		summarize();
	end
endmodule
